// ==== pfgpio_defs.svh ====
// Offsets, field positions and reset values of the port F pin multiplexer
`ifndef PFGPIO_DEFS_SVH
`define PFGPIO_DEFS_SVH
// Register indexes, byte address is four times the index
`define PFGPIO_IDX_DIR     16'hfebe
`define PFGPIO_IDX_PIN     16'hff5e
`define PFGPIO_IDX_LAT     16'hff6e
`define PFGPIO_IDX_CTL     16'hff70
`define PFGPIO_ADDR_W      18
// Reset values
`define PFGPIO_DIR_RST_BUS 8'h80
`define PFGPIO_DIR_RST_SC  8'h00
`define PFGPIO_LAT_RST     8'h00
`define PFGPIO_CTL_RST     4'h0
// Control register field positions
`define PFGPIO_CTL_HOLD_SEL    0
`define PFGPIO_CTL_REQ_OUT_EN  1
`define PFGPIO_CTL_WAIT_EN     2
`define PFGPIO_CTL_REL_EN      3
// Single-chip modes
`define PFGPIO_MODE_SC_A   3'h3
`define PFGPIO_MODE_SC_B   3'h7
// AXI responses
`define PFGPIO_RESP_OKAY   2'h0
`define PFGPIO_RESP_SLVERR 2'h2
`endif

// ==== pfgpio_pkg.sv ====
// Types of the port F pin multiplexer
`default_nettype none
package pfgpio_pkg;
  typedef enum logic [2:0]
  {
    PFGPIO_SEL_NONE = 3'h0,
    PFGPIO_SEL_DIR  = 3'h1,
    PFGPIO_SEL_PIN  = 3'h2,
    PFGPIO_SEL_LAT  = 3'h3,
    PFGPIO_SEL_CTL  = 3'h4
  } pfgpio_sel_t;
  typedef struct packed {
    logic bus_release_enable;
    logic wait_pin_enable;
    logic bus_request_output_enable;
    logic standby_output_hold_select;
  } pfgpio_ctl_t;
  // Bus control strobes, all active low
  typedef struct packed {
    logic address_strobe_n;
    logic read_strobe_n;
    logic high_byte_write_strobe_n;
    logic low_byte_write_strobe_n;
    logic bus_request_output_n;
    logic bus_grant_ack_n;
  } pfgpio_bus_ctl_t;
endpackage
`default_nettype wire

// ==== pfgpio.sv ====
// Port F general I/O with bus control, clock output and interrupt pin functions
`include "pfgpio_defs.svh"
`default_nettype none
module pfgpio
(
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [`PFGPIO_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`PFGPIO_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // System state
  input  wire logic [2:0]                  mode_pins,
  input  wire logic                        hw_standby_pin,
  input  wire logic                        manual_reset,
  input  wire logic                        sw_standby,
  // From bus controller and clock generator
  input  wire pfgpio_pkg::pfgpio_bus_ctl_t bus_ctl,
  input  wire logic                        system_clock_level,
  // To bus controller and interrupt logic
  output logic                             wait_n,
  output logic                             bus_request_input_n,
  output logic [3:0]                       external_interrupt_n,
  // Port F pins
  input  wire logic [7:0]                  pin_in,
  output logic [7:0]                       pin_out,
  output logic [7:0]                       pin_oe_n
);

  logic [2:0]              mode_meta_ff;
  logic [2:0]              mode_sync_ff;
  logic [2:0]              mode_ff;
  logic                    hws_meta_ff;
  logic                    hws_ff;
  logic [7:0]              pin_meta_ff;
  logic [7:0]              pin_sync_ff;
  logic [7:0]              dir_ff;
  logic [7:0]              lat_ff;
  logic [7:0]              pin_state_ff;
  pfgpio_pkg::pfgpio_ctl_t ctl_ff;
  logic [7:0]              nxt_pin_out;
  logic [7:0]              nxt_pin_oe_n;
  logic [7:0]              bus_fn;
  logic                    bus_mode;
  logic                    init;
  logic [`PFGPIO_ADDR_W-1:0] awaddr_ff;
  logic                    aw_held_ff;
  logic [7:0]              wdata_ff;
  logic                    wstrb0_ff;
  logic                    w_held_ff;
  logic                    wr_go;
  pfgpio_pkg::pfgpio_sel_t wr_sel;
  pfgpio_pkg::pfgpio_sel_t rd_sel;
  logic                    wr_en;
  logic [7:0]              rd_byte;
  logic [7:0]              pin_view;
  function automatic pfgpio_pkg::pfgpio_sel_t decode(input logic [`PFGPIO_ADDR_W-1:0] a);
    unique case (a[`PFGPIO_ADDR_W-1:2])
      `PFGPIO_IDX_DIR: decode = pfgpio_pkg::PFGPIO_SEL_DIR;
      `PFGPIO_IDX_PIN: decode = pfgpio_pkg::PFGPIO_SEL_PIN;
      `PFGPIO_IDX_LAT: decode = pfgpio_pkg::PFGPIO_SEL_LAT;
      `PFGPIO_IDX_CTL: decode = pfgpio_pkg::PFGPIO_SEL_CTL;
      default:         decode = pfgpio_pkg::PFGPIO_SEL_NONE;
    endcase
  endfunction
  function automatic logic is_bus_mode(input logic [2:0] m);
    is_bus_mode = (m != `PFGPIO_MODE_SC_A) && (m != `PFGPIO_MODE_SC_B);
  endfunction
  // Synchronisers for pins
  always_ff @(posedge aclk)
  begin
    mode_meta_ff <= mode_pins;
    mode_sync_ff <= mode_meta_ff;
    hws_meta_ff  <= hw_standby_pin;
    hws_ff       <= hws_meta_ff;
    pin_meta_ff  <= pin_in;
    pin_sync_ff  <= pin_meta_ff;
  end
  // Mode straps are caught while reset is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_ff <= mode_sync_ff;
  end
  assign bus_mode = is_bus_mode(mode_ff);
  assign init     = !aresetn || hws_ff;
  // AXI write channel capture, address and data in either order
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
  assign wr_go         = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_sel        = decode(awaddr_ff);
  assign wr_en         = wr_go && wstrb0_ff && !hws_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff  <= 8'h00;
      wstrb0_ff <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end
    else if (wr_go)
      w_held_ff <= 1'b0;
  end
  // Write response; pin-state writes are accepted and dropped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PFGPIO_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == pfgpio_pkg::PFGPIO_SEL_NONE) ?
                      `PFGPIO_RESP_SLVERR : `PFGPIO_RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  // Manual reset and software standby leave it alone
  always_ff @(posedge aclk)
  begin
    if (init)
      dir_ff <= is_bus_mode(!aresetn ? mode_sync_ff : mode_ff) ?
                `PFGPIO_DIR_RST_BUS : `PFGPIO_DIR_RST_SC;
    else if (wr_en && wr_sel == pfgpio_pkg::PFGPIO_SEL_DIR)
      dir_ff <= wdata_ff;
  end
  always_ff @(posedge aclk)
  begin
    if (init)
      lat_ff <= `PFGPIO_LAT_RST;
    else if (wr_en && wr_sel == pfgpio_pkg::PFGPIO_SEL_LAT)
      lat_ff <= wdata_ff;
  end
  // Bus control enables; cleared with the port so pins start as plain I/O
  always_ff @(posedge aclk)
  begin
    if (init)
      ctl_ff <= `PFGPIO_CTL_RST;
    else if (wr_en && wr_sel == pfgpio_pkg::PFGPIO_SEL_CTL)
      ctl_ff <= wdata_ff[3:0];
  end
  // Latch bits for outputs, pin levels for inputs
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_view[i] = dir_ff[i] ? lat_ff[i] : pin_sync_ff[i];
  end
  // Frozen during manual reset and software standby
  always_ff @(posedge aclk)
  begin
    if (init || !(manual_reset || sw_standby))
      pin_state_ff <= init ? pin_sync_ff : pin_view;
  end
  // Direction reads give zero, never the contents
  always_comb
  begin
    unique case (rd_sel)
      pfgpio_pkg::PFGPIO_SEL_PIN: rd_byte = pin_state_ff;
      pfgpio_pkg::PFGPIO_SEL_LAT: rd_byte = lat_ff;
      pfgpio_pkg::PFGPIO_SEL_CTL: rd_byte = {4'h0, ctl_ff};
      default:                    rd_byte = 8'h00;
    endcase
  end
  // AXI read: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel        = decode(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PFGPIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= (rd_sel == pfgpio_pkg::PFGPIO_SEL_NONE) ?
                      `PFGPIO_RESP_SLVERR : `PFGPIO_RESP_OKAY;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
  // Pin multiplexer
  always_comb
  begin
    bus_fn = 8'h00;
    // General I/O drives exactly when direction is 1
    for (int i = 0; i < 8; i++)
    begin
      nxt_pin_out[i]  = lat_ff[i];
      nxt_pin_oe_n[i] = !dir_ff[i];
    end
    nxt_pin_out[7] = system_clock_level;
    if (bus_mode)
    begin
      bus_fn[6:3]      = 4'hf;
      nxt_pin_out[6]   = bus_ctl.address_strobe_n;
      nxt_pin_out[5]   = bus_ctl.read_strobe_n;
      nxt_pin_out[4]   = bus_ctl.high_byte_write_strobe_n;
      nxt_pin_out[3]   = bus_ctl.low_byte_write_strobe_n;
      nxt_pin_oe_n[6:3] = 4'h0;
      // Bus request beats wait beats general I/O
      if (ctl_ff.bus_request_output_enable)
      begin
        bus_fn[2]       = 1'b1;
        nxt_pin_out[2]  = bus_ctl.bus_request_output_n;
        nxt_pin_oe_n[2] = 1'b0;
      end
      else if (ctl_ff.wait_pin_enable)
        nxt_pin_oe_n[2] = 1'b1;
      // Bus grant acknowledge on pin 1
      if (ctl_ff.bus_release_enable)
      begin
        bus_fn[1]       = 1'b1;
        nxt_pin_out[1]  = bus_ctl.bus_grant_ack_n;
        nxt_pin_oe_n[1] = 1'b0;
        nxt_pin_oe_n[0] = 1'b1;
      end
    end
    // Standby holds or floats bus control outputs
    if (sw_standby)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (bus_fn[i])
        begin
          nxt_pin_out[i]  = pin_out[i];
          nxt_pin_oe_n[i] = !ctl_ff.standby_output_hold_select;
        end
      end
    end
  end
  // Registered pin drive, all floating in init
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out  <= 8'h00;
      pin_oe_n <= 8'hff;
    end
    else
    begin
      pin_out  <= nxt_pin_out;
      pin_oe_n <= hws_ff ? 8'hff : nxt_pin_oe_n;
    end
  end
  // Inputs towards bus controller and interrupt logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wait_n               <= 1'b1;
      bus_request_input_n  <= 1'b1;
      external_interrupt_n <= 4'hf;
    end
    else
    begin
      wait_n               <= !(bus_mode && ctl_ff.wait_pin_enable &&
                                !ctl_ff.bus_request_output_enable) || pin_sync_ff[2];
      bus_request_input_n  <= !(bus_mode && ctl_ff.bus_release_enable) || pin_sync_ff[0];
      external_interrupt_n <= pin_sync_ff[3:0];
    end
  end

endmodule
`default_nettype wire

// ==== pfgpio_pins.sv ====
// Pin model: each pin shows the device drive or the far side level
`default_nettype none
module pfgpio_pins
(
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  // Far side
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device drive wins where enabled
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule
`default_nettype wire

// ==== pfgpio_chk.sv ====
// Port level assertions of the port F multiplexer
`include "pfgpio_defs.svh"
`default_nettype none
module pfgpio_chk
(
  // Clock, reset, state
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [2:0]                mode_pins,
  input  wire logic                      hw_standby_pin,
  input  wire logic                      sw_standby,
  input  wire pfgpio_pkg::pfgpio_bus_ctl_t bus_ctl,
  input  wire logic                      system_clock_level,
  // Read channel and write response valid
  input  wire logic [`PFGPIO_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  input  wire logic                      s_axi_arready,
  input  wire logic [31:0]               s_axi_rdata,
  input  wire logic [1:0]                s_axi_rresp,
  input  wire logic                      s_axi_rvalid,
  input  wire logic                      s_axi_bvalid,
  // Pins
  input  wire logic [7:0]                pin_out,
  input  wire logic [7:0]                pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] md_ff;
  logic [3:0] hs_ff;
  logic       rd_dir_ff;
  logic       rd_pin_ff;
  logic       bus;
  logic       quiet;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      md_ff <= mode_pins;
    hs_ff <= {hs_ff[2:0], hw_standby_pin};
  end
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
    begin
      rd_dir_ff <= s_axi_araddr[17:2] == `PFGPIO_IDX_DIR;
      rd_pin_ff <= s_axi_araddr[17:2] == `PFGPIO_IDX_PIN;
    end
  end
  // Standby sync flops take a few cycles to settle
  assign bus = md_ff != `PFGPIO_MODE_SC_A && md_ff != `PFGPIO_MODE_SC_B;
  assign quiet = !aresetn || hw_standby_pin || (|hs_ff);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (quiet);
  sequence s_rd_done;
    $rose(s_axi_rvalid);
  endsequence
  AST_DIR_INIT_BUS: assert property ($rose(aresetn) && bus |-> ##[1:2] !pin_oe_n[7])
    else $error("clock pin not driven after reset");
  AST_DIR_INIT_SC: assert property ($rose(aresetn) && !bus |=> (pin_oe_n == 8'hff) [*2])
    else $error("pin driven after reset");
  AST_CLK_PIN: assert property (!pin_oe_n[7] && $past(aresetn) && !sw_standby
    && !$past(sw_standby) |-> pin_out[7] == $past(system_clock_level))
    else $error("clock pin level wrong");
  AST_STROBES: assert property (bus && !sw_standby && !$past(sw_standby) && $past(aresetn)
    |-> pin_oe_n[6:3] == 4'h0 && pin_out[6:3] == $past(bus_ctl[5:2]))
    else $error("strobe pins wrong");
  AST_STBY_HOLD: assert property (bus && sw_standby && $past(sw_standby)
    |-> $stable(pin_out[6:3])) else $error("strobe level moved in standby");
  AST_DIR_RD_ZERO: assert property (s_rd_done ##0 rd_dir_ff
    |-> s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `PFGPIO_RESP_OKAY)
    else $error("direction read not zero");
  AST_PIN_RD: assert property (s_rd_done ##0 (rd_pin_ff && !bus)
    |-> ((s_axi_rdata[6:0] ^ pin_out[6:0]) & ~pin_oe_n[6:0]) == 7'h00
    && s_axi_rdata[31:8] == 24'h00_0000) else $error("pin state read wrong");
  AST_SC_NO_STROBE: assert property (!bus && !$stable(pin_out[6:0])
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("output moved without write");
endmodule
bind pfgpio pfgpio_chk i_pfgpio_chk (.aclk, .aresetn, .mode_pins, .hw_standby_pin,
  .sw_standby, .bus_ctl, .system_clock_level, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .pin_out,
  .pin_oe_n);
`default_nettype wire

// ==== pfgpio_tb_top.sv ====
// Register and pin tests of the port F multiplexer
`include "pfgpio_defs.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module pfgpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, hw_standby_pin, manual_reset, sw_standby, system_clock_level;
  logic        wait_n, bus_request_input_n;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, external_interrupt_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  mode_pins;
  logic [7:0]  pin_in, pin_out, pin_oe_n, ext_lvl;
  int          error_cnt, n_tests;
  pfgpio_pkg::pfgpio_bus_ctl_t bus_ctl;
  pfgpio i_pfgpio (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_pins, .hw_standby_pin,
    .manual_reset, .sw_standby, .bus_ctl, .system_clock_level, .wait_n,
    .bus_request_input_n, .external_interrupt_n, .pin_in, .pin_out, .pin_oe_n);
  pfgpio_pins i_pfgpio_pins (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);
  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
    system_clock_level <= ~system_clock_level;
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] m, input logic [7:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    `CHK("rresp", er, s_axi_rresp)
    `CHK("rdata", {24'h00_0000, e & m}, s_axi_rdata & {24'hff_ffff, m})
  endtask
  task automatic rst(input logic [2:0] m);
    aresetn <= 1'h0;
    mode_pins <= m;
    tick(16);
    aresetn <= 1'h1;
    tick(4);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {aresetn, hw_standby_pin, manual_reset, sw_standby, system_clock_level} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
    s_axi_wstrb = 4'hf;
    mode_pins = 3'h5;
    ext_lvl = 8'h00;
    bus_ctl = 6'h29;
    // Bus mode
    rst(3'h5);
    `CHK("oe", 8'h07, pin_oe_n)
    rd(`PFGPIO_IDX_DIR, 8'hff, 8'h00, `PFGPIO_RESP_OKAY);
    rd(`PFGPIO_IDX_LAT, 8'hff, 8'h00, `PFGPIO_RESP_OKAY);
    rd(16'h0000, 8'h00, 8'h00, `PFGPIO_RESP_SLVERR);
    wr(`PFGPIO_IDX_LAT, 8'h05, `PFGPIO_RESP_OKAY);
    wr(`PFGPIO_IDX_DIR, 8'h87, `PFGPIO_RESP_OKAY);
    tick(3);
    `CHK("oe", 8'h00, pin_oe_n)
    `CHK("out", 7'h55, pin_out[6:0])
    wr(`PFGPIO_IDX_PIN, 8'hff, `PFGPIO_RESP_OKAY);
    rd(`PFGPIO_IDX_LAT, 8'hff, 8'h05, `PFGPIO_RESP_OKAY);
    rd(`PFGPIO_IDX_PIN, 8'h87, 8'h05, `PFGPIO_RESP_OKAY);
    // A write with byte lane 0 off must leave the latch alone
    s_axi_wstrb <= 4'h0;
    wr(`PFGPIO_IDX_LAT, 8'hff, `PFGPIO_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`PFGPIO_IDX_LAT, 8'hff, 8'h05, `PFGPIO_RESP_OKAY);
    wr(`PFGPIO_IDX_CTL, 8'h0a, `PFGPIO_RESP_OKAY);
    tick(3);
    `CHK("req", 5'h09, {pin_out[2:1], pin_oe_n[2:0]})
    wr(`PFGPIO_IDX_DIR, 8'h80, `PFGPIO_RESP_OKAY);
    tick(6);
    `CHK("oe", 8'h01, pin_oe_n)
    `CHK("bus_request_input", 1'h0, bus_request_input_n)
    wr(`PFGPIO_IDX_CTL, 8'h04, `PFGPIO_RESP_OKAY);
    tick(6);
    `CHK("wait", 1'h0, wait_n)
    ext_lvl <= 8'h04;
    tick(6);
    `CHK("wait", 1'h1, wait_n)
    `CHK("irq", 4'h4, external_interrupt_n)
    wr(`PFGPIO_IDX_CTL, 8'h01, `PFGPIO_RESP_OKAY);
    sw_standby <= 1'h1;
    bus_ctl <= 6'h15;
    tick(3);
    `CHK("hold", 8'ha0, {pin_out[6:3], pin_oe_n[6:3]})
    sw_standby <= 1'h0;
    wr(`PFGPIO_IDX_CTL, 8'h00, `PFGPIO_RESP_OKAY);
    sw_standby <= 1'h1;
    tick(3);
    `CHK("float", 4'hf, pin_oe_n[6:3])
    sw_standby <= 1'h0;
    ext_lvl <= 8'h03;
    tick(6);
    manual_reset <= 1'h1;
    ext_lvl <= 8'h04;
    tick(6);
    rd(`PFGPIO_IDX_PIN, 8'h87, 8'h03, `PFGPIO_RESP_OKAY);
    manual_reset <= 1'h0;
    tick(6);
    `CHK("oe", 8'h07, pin_oe_n)
    rd(`PFGPIO_IDX_LAT, 8'hff, 8'h05, `PFGPIO_RESP_OKAY);
    rd(`PFGPIO_IDX_PIN, 8'h87, 8'h04, `PFGPIO_RESP_OKAY);
    // Single chip mode
    rst(3'h3);
    `CHK("oe", 8'hff, pin_oe_n)
    wr(`PFGPIO_IDX_LAT, 8'h5a, `PFGPIO_RESP_OKAY);
    wr(`PFGPIO_IDX_DIR, 8'h7f, `PFGPIO_RESP_OKAY);
    ext_lvl <= 8'ha5;
    bus_ctl <= 6'h00;
    tick(6);
    `CHK("oe", 8'h80, pin_oe_n)
    `CHK("out", 7'h5a, pin_out[6:0])
    rd(`PFGPIO_IDX_PIN, 8'hff, 8'hda, `PFGPIO_RESP_OKAY);
    hw_standby_pin <= 1'h1;
    tick(6);
    hw_standby_pin <= 1'h0;
    tick(8);
    `CHK("oe", 8'hff, pin_oe_n)
    rd(`PFGPIO_IDX_LAT, 8'hff, 8'h00, `PFGPIO_RESP_OKAY);
    rd(`PFGPIO_IDX_PIN, 8'hff, 8'ha5, `PFGPIO_RESP_OKAY);
    wrap_up();
  end
  // Tests need well under two thousand cycles
  initial
  begin
    tick(20000);
    error_cnt++;
    $display("BAD run_end exp %s got %s", "done", "timeout");
    wrap_up();
  end
endmodule
`default_nettype wire
